// ==== hw/mpm_pkg.sv ====
`default_nettype none

package mpm_pkg;

  // Register indices and byte addresses (byte address = 4 * index)
  localparam logic [7:0]  REG_CTRL_IDX    = 8'h1f;
  localparam logic [7:0]  REG_SCANOP_IDX  = 8'h2e;
  localparam logic [7:0]  REG_REGSEL_IDX  = 8'h1b;
  localparam logic [7:0]  REG_RESULT_IDX  = 8'h30;
  localparam logic [11:0] ADDR_CTRL       = {2'b00, REG_CTRL_IDX, 2'b00};
  localparam logic [11:0] ADDR_SCANOP     = {2'b00, REG_SCANOP_IDX, 2'b00};
  localparam logic [11:0] ADDR_REGSEL     = {2'b00, REG_REGSEL_IDX, 2'b00};
  localparam logic [11:0] ADDR_RESULT     = {2'b00, REG_RESULT_IDX, 2'b00};

  // Field positions
  localparam int unsigned TIMEOUT_ARM_BIT = 1;
  localparam int unsigned REGSEL_BIT      = 1;
  localparam int unsigned MODE_LSB        = 6;

  // Reset values
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [7:0]  SCANOP_RST      = 8'h00;
  localparam logic [7:0]  REGSEL_RST      = 8'h00;
  localparam logic [15:0] RESULT_RST      = 16'h0000;

  // Mode field encodings
  localparam logic [1:0]  MODE_IDLE       = 2'h0;
  localparam logic [1:0]  MODE_SCAN       = 2'h1;
  localparam logic [1:0]  MODE_LOWPWR     = 2'h2;
  localparam logic [1:0]  MODE_STORAGE_DORMANT_MODE       = 2'h3;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // Timing, in the unit named, then cycles at the clock rate
  localparam int unsigned CLK_KHZ         = 100000;
  localparam int unsigned SILENCE_MS      = 4000;
  localparam int unsigned LP_PERIOD_MS    = 2000;
  localparam int unsigned LP_WINDOW_MS    = 1;
  localparam int unsigned SILENCE_CYC     = SILENCE_MS * CLK_KHZ;
  localparam int unsigned LP_PERIOD_CYC   = LP_PERIOD_MS * CLK_KHZ;
  localparam int unsigned LP_WINDOW_CYC   = LP_WINDOW_MS * CLK_KHZ;

  // Operating mode, one-hot
  typedef enum logic [3:0] {
    MPM_IDLE   = 4'b0001,
    MPM_SCAN   = 4'b0010,
    MPM_LOWPWR = 4'b0100,
    MPM_STORAGE_DORMANT_MODE   = 4'b1000
  } mpm_mode_e;

endpackage

`default_nettype wire

// ==== hw/mpm_power_mode.sv ====
// Behaviour
// R01 - Bit 1 of the battery-voltage control register arms the link-silence timeout.
// R02 - Armed and idle, about four seconds without host traffic moves the device to low power.
// R03 - The present mode reads back from the scan-operation register.
// R04 - In low power the measurement circuitry is powered for a short window every two seconds.
// R05 - In low power new results skip the data register but still go to fault comparison.
// R06 - Leaving low power for scan or idle copies the latest result into the data register.
// R07 - In low power with regulator select clear the strong regulator runs only in windows.
// R08 - In storage_dormant_mode mode nothing runs but waiting for wake-up, reset or a mode write.
// R09 - In storage_dormant_mode mode any access other than to the scan-operation register is refused.
// R10 - In storage_dormant_mode mode the strong regulator stays on when regulator select is one.
// R11 - In storage_dormant_mode mode only the weak regulator runs when regulator select is zero.
// R12 - Mode lives in scan-operation bits 7:6; writing 00 selects idle.
// R13 - Wake-up pin assertion in storage_dormant_mode mode returns to idle and reads back as idle.
// R14 - Every completed bus transaction restarts the silence interval.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module mpm_power_mode #(
  parameter int unsigned SILENCE_CYC   = mpm_pkg::SILENCE_CYC,
  parameter int unsigned LP_PERIOD_CYC = mpm_pkg::LP_PERIOD_CYC,
  parameter int unsigned LP_WINDOW_CYC = mpm_pkg::LP_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Wake-up pin, asynchronous
  input  wire logic        wakeup_n,
  // Measurement engine
  input  wire logic        meas_result_valid,
  input  wire logic [15:0] meas_result,
  output logic             meas_power_en,
  output logic             fault_compare_valid,
  output logic [15:0]      fault_compare_data,
  // Regulator control
  output logic             strong_regulator_en
);

  // Register selector codes returned by the decoder
  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_CTRL   = 3'h1;
  localparam logic [2:0] SEL_SCANOP = 3'h2;
  localparam logic [2:0] SEL_REGSEL = 3'h3;
  localparam logic [2:0] SEL_RESULT = 3'h4;

  // Address to register selector
  function automatic logic [2:0] decode(input logic [11:0] addr);
    unique case (addr)
      mpm_pkg::ADDR_CTRL:   decode = SEL_CTRL;
      mpm_pkg::ADDR_SCANOP: decode = SEL_SCANOP;
      mpm_pkg::ADDR_REGSEL: decode = SEL_REGSEL;
      mpm_pkg::ADDR_RESULT: decode = SEL_RESULT;
      default:              decode = SEL_NONE;
    endcase
  endfunction

  // Mode field to one-hot state
  function automatic mpm_pkg::mpm_mode_e field_to_mode(input logic [1:0] f);
    unique case (f)
      mpm_pkg::MODE_IDLE:   field_to_mode = mpm_pkg::MPM_IDLE;
      mpm_pkg::MODE_SCAN:   field_to_mode = mpm_pkg::MPM_SCAN;
      mpm_pkg::MODE_LOWPWR: field_to_mode = mpm_pkg::MPM_LOWPWR;
      default:              field_to_mode = mpm_pkg::MPM_STORAGE_DORMANT_MODE;
    endcase
  endfunction

  // One-hot state to mode field
  function automatic logic [1:0] mode_to_field(input mpm_pkg::mpm_mode_e m);
    unique case (m)
      mpm_pkg::MPM_IDLE:   mode_to_field = mpm_pkg::MODE_IDLE;
      mpm_pkg::MPM_SCAN:   mode_to_field = mpm_pkg::MODE_SCAN;
      mpm_pkg::MPM_LOWPWR: mode_to_field = mpm_pkg::MODE_LOWPWR;
      default:             mode_to_field = mpm_pkg::MODE_STORAGE_DORMANT_MODE;
    endcase
  endfunction

  mpm_pkg::mpm_mode_e mode_ff;
  mpm_pkg::mpm_mode_e nxt_mode;
  logic        aw_have_ff;
  logic        w_have_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic        wstrb0_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [7:0]  ctrl_ff;
  logic [5:0]  scanop_low_ff;
  logic [7:0]  regsel_ff;
  logic [15:0] result_ff;
  logic [15:0] shadow_ff;
  logic        shadow_new_ff;
  logic [31:0] silence_cnt_ff;
  logic [31:0] lp_cnt_ff;
  logic        wake_meta_ff;
  logic        wake_sync_ff;
  logic        wake_prev_ff;
  logic        cmp_valid_ff;
  logic [15:0] cmp_data_ff;
  logic        do_write;
  logic [2:0]  wsel;
  logic [2:0]  rsel;
  logic        storage_dormant_mode;
  logic        w_refused;
  logic        mode_write;
  logic        silence_hit;
  logic        wake_event;
  logic        lp_window;
  logic        bus_done;

  assign storage_dormant_mode        = (mode_ff == mpm_pkg::MPM_STORAGE_DORMANT_MODE);
  assign wsel        = decode(awaddr_ff);
  assign rsel        = decode(s_axi_araddr);
  assign do_write    = aw_have_ff && w_have_ff && !bvalid_ff;
  assign w_refused   = storage_dormant_mode && (wsel != SEL_SCANOP);                  // R09
  assign mode_write  = do_write && !w_refused && wstrb0_ff && (wsel == SEL_SCANOP);
  assign bus_done    = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
  assign lp_window   = (mode_ff == mpm_pkg::MPM_LOWPWR) && (lp_cnt_ff < LP_WINDOW_CYC);

  // Bus handshakes
  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write address and data capture, either order
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= 12'h000;
      wdata_ff   <= 32'h0000_0000;
      wstrb0_ff  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_have_ff <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= mpm_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      if (wsel == SEL_NONE)
        bresp_ff <= mpm_pkg::RESP_DECERR;
      else if (w_refused)
        bresp_ff <= mpm_pkg::RESP_SLVERR;                              // R09
      else
        bresp_ff <= mpm_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // Software registers; result register is read-only
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ctrl_ff       <= mpm_pkg::CTRL_RST;
      scanop_low_ff <= mpm_pkg::SCANOP_RST[5:0];
      regsel_ff     <= mpm_pkg::REGSEL_RST;
    end
    else if (do_write && !w_refused && wstrb0_ff)
    begin
      unique case (wsel)
        SEL_CTRL:   ctrl_ff       <= wdata_ff[7:0];                    // R01
        SEL_SCANOP: scanop_low_ff <= wdata_ff[5:0];
        SEL_REGSEL: regsel_ff     <= wdata_ff[7:0];
        default:    ;
      endcase
    end
  end

  // Read channel
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= mpm_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= mpm_pkg::RESP_OKAY;
      if (rsel == SEL_NONE)
        rresp_ff <= mpm_pkg::RESP_DECERR;
      else if (storage_dormant_mode && rsel != SEL_SCANOP)
        rresp_ff <= mpm_pkg::RESP_SLVERR;                              // R09
      else
      begin
        unique case (rsel)
          SEL_CTRL:   rdata_ff[7:0]  <= ctrl_ff;
          SEL_SCANOP: rdata_ff[7:0]  <= {mode_to_field(mode_ff), scanop_low_ff}; // R03
          SEL_REGSEL: rdata_ff[7:0]  <= regsel_ff;
          default:    rdata_ff[15:0] <= result_ff;
        endcase
      end
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // Wake-up pin synchroniser and assertion edge
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wake_meta_ff <= 1'b0;
      wake_sync_ff <= 1'b0;
      wake_prev_ff <= 1'b0;
    end
    else
    begin
      wake_meta_ff <= !wakeup_n;
      wake_sync_ff <= wake_meta_ff;
      wake_prev_ff <= wake_sync_ff;
    end
  end
  assign wake_event = wake_sync_ff && !wake_prev_ff;

  // Link-silence counter, runs only while armed and idle
  always_ff @(posedge clock)
  begin
    if (srst)
      silence_cnt_ff <= 32'h0000_0000;
    else if (bus_done || mode_ff != mpm_pkg::MPM_IDLE ||
             !ctrl_ff[mpm_pkg::TIMEOUT_ARM_BIT])                       // R01 R14
      silence_cnt_ff <= 32'h0000_0000;
    else if (!silence_hit)
      silence_cnt_ff <= silence_cnt_ff + 32'h0000_0001;
  end
  assign silence_hit = (silence_cnt_ff == SILENCE_CYC - 1);            // R02

  // Mode selection; hardware events win over a coincident host write
  always_comb
  begin
    nxt_mode = mode_ff;
    if (mode_write)
      nxt_mode = field_to_mode(wdata_ff[mpm_pkg::MODE_LSB +: 2]);      // R12
    if (storage_dormant_mode && wake_event)
      nxt_mode = mpm_pkg::MPM_IDLE;                                    // R13
    else if (mode_ff == mpm_pkg::MPM_IDLE && silence_hit && !bus_done)
      nxt_mode = mpm_pkg::MPM_LOWPWR;                                  // R02
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      mode_ff <= mpm_pkg::MPM_IDLE;
    else
      mode_ff <= nxt_mode;
  end

  // Low-power duty-cycle timer, restarts on entry
  always_ff @(posedge clock)
  begin
    if (srst || mode_ff != mpm_pkg::MPM_LOWPWR)
      lp_cnt_ff <= 32'h0000_0000;
    else if (lp_cnt_ff == LP_PERIOD_CYC - 1)
      lp_cnt_ff <= 32'h0000_0000;                                      // R04
    else
      lp_cnt_ff <= lp_cnt_ff + 32'h0000_0001;
  end

  // Measurement power: always in scan/idle, windowed in low power, off in storage_dormant_mode
  assign meas_power_en = (mode_ff == mpm_pkg::MPM_SCAN) ||
                         (mode_ff == mpm_pkg::MPM_IDLE) || lp_window;  // R04 R08

  // Strong regulator: on except, with select clear, in low-power gaps and in storage_dormant_mode
  always_comb
  begin
    unique case (mode_ff)
      mpm_pkg::MPM_LOWPWR: strong_regulator_en = regsel_ff[mpm_pkg::REGSEL_BIT] ||
                                                 lp_window;            // R07
      mpm_pkg::MPM_STORAGE_DORMANT_MODE:   strong_regulator_en = regsel_ff[mpm_pkg::REGSEL_BIT]; // R10 R11
      default:             strong_regulator_en = 1'b1;
    endcase
  end

  // Results to fault comparison in every active mode
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cmp_valid_ff <= 1'b0;
      cmp_data_ff  <= mpm_pkg::RESULT_RST;
    end
    else
    begin
      cmp_valid_ff <= meas_result_valid && !storage_dormant_mode;                      // R05 R08
      if (meas_result_valid && !storage_dormant_mode)
        cmp_data_ff <= meas_result;
    end
  end
  assign fault_compare_valid = cmp_valid_ff;
  assign fault_compare_data  = cmp_data_ff;

  // Data register direct in idle and scan; shadow copied on exit to either
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      result_ff     <= mpm_pkg::RESULT_RST;
      shadow_ff     <= mpm_pkg::RESULT_RST;
      shadow_new_ff <= 1'b0;
    end
    else if (mode_ff == mpm_pkg::MPM_LOWPWR)
    begin
      if (meas_result_valid)
      begin
        shadow_ff     <= meas_result;                                  // R05
        shadow_new_ff <= 1'b1;
      end
      if ((nxt_mode == mpm_pkg::MPM_IDLE || nxt_mode == mpm_pkg::MPM_SCAN) &&
          (shadow_new_ff || meas_result_valid))
      begin
        result_ff     <= meas_result_valid ? meas_result : shadow_ff;  // R06
        shadow_new_ff <= 1'b0;
      end
    end
    else
    begin
      shadow_new_ff <= 1'b0;
      if (meas_result_valid && !storage_dormant_mode)
        result_ff <= meas_result;
    end
  end

endmodule // mpm_power_mode

`default_nettype wire

// ==== verification/mpm_power_mode_chk.sv ====
`timescale 1ns/10ps
`default_nettype none

module mpm_power_mode_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Measurement and regulator
  input wire logic        meas_result_valid,
  input wire logic [15:0] meas_result,
  input wire logic        meas_power_en,
  input wire logic        fault_compare_valid,
  input wire logic [15:0] fault_compare_data,
  input wire logic        strong_regulator_en
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // Bus steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  wr_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  fault_copy_a: assert property (fault_compare_valid |->
    $past(meas_result_valid) && fault_compare_data == $past(meas_result))
    else $error("fault compare data not from last result");
  strong_window_a: assert property (meas_power_en |-> strong_regulator_en)
    else $error("weak regulator while measuring");
endmodule // mpm_power_mode_chk

bind mpm_power_mode mpm_power_mode_chk CHK (.clock, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .meas_result_valid, .meas_result, .meas_power_en,
  .fault_compare_valid, .fault_compare_data, .strong_regulator_en);

`default_nettype wire

// ==== verification/mpm_host.sv ====
`timescale 1ns/10ps
`default_nettype none

module mpm_host (
  // Clock
  input  wire logic        clock,
  // Write channels
  output logic             awvalid,
  input  wire logic        awready,
  output logic [11:0]      awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // Read channels
  output logic             arvalid,
  input  wire logic        arready,
  output logic [11:0]      araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  // Quiet bus at time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 28'h0000000;
    wdata = 32'h00000000;
  end

  // Write; released lines are scrambled, not left at the old value
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    @(posedge clock);
    {awvalid, awaddr, wvalid, wdata, wstrb} <= {1'b1, a, 1'b1, d, 4'hf};
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok)
    begin
      @(negedge clock);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      r = bresp;
      @(posedge clock);
      if (aw_ok) {awvalid, awaddr} <= {1'b0, ~awaddr};
      if (w_ok) {wvalid, wdata} <= {1'b0, ~wdata};
      if (b_ok) bready <= 1'b0;
    end
  endtask

  // Read
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok;
    logic r_ok;
    @(posedge clock);
    {arvalid, araddr, rready} <= {1'b1, a, 1'b1};
    r_ok = 1'b0;
    while (!r_ok)
    begin
      @(negedge clock);
      ar_ok = arvalid && arready;
      r_ok = rvalid && rready;
      {d, r} = {rdata, rresp};
      @(posedge clock);
      if (ar_ok) {arvalid, araddr} <= {1'b0, ~araddr};
      if (r_ok) rready <= 1'b0;
    end
  endtask
endmodule // mpm_host

`default_nettype wire

// ==== verification/mpm_power_mode_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module mpm_power_mode_tb;
  localparam int SIL = 50;
  localparam int PER = 40;
  localparam int WIN = 5;
  localparam logic [1:0]  OK = mpm_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = mpm_pkg::RESP_SLVERR;
  localparam logic [11:0] A_CTL = mpm_pkg::ADDR_CTRL;
  localparam logic [11:0] A_SCN = mpm_pkg::ADDR_SCANOP;
  localparam logic [11:0] A_REG = mpm_pkg::ADDR_REGSEL;
  localparam logic [11:0] A_RES = mpm_pkg::ADDR_RESULT;
  // Stimulus and observed signals
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        wakeup_n = 1'b1;
  logic        mrv = 1'b0;
  logic [15:0] mres = 16'h0000;
  logic        awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, mpe, fcv, sre;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd_;
  logic [3:0]  ws;
  logic [1:0]  bre, rre;
  logic [15:0] fcd;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #5 clock = ~clock;

  mpm_power_mode #(.SILENCE_CYC(SIL), .LP_PERIOD_CYC(PER), .LP_WINDOW_CYC(WIN)) DUT (
    .clock(clock), .srst(srst), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd_), .s_axi_rresp(rre), .wakeup_n(wakeup_n), .meas_result_valid(mrv),
    .meas_result(mres), .meas_power_en(mpe), .fault_compare_valid(fcv),
    .fault_compare_data(fcd), .strong_regulator_en(sre));
  mpm_host HOST (.clock(clock), .awvalid(awv), .awready(awr), .awaddr(awa), .wvalid(wv),
    .wready(wr_), .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(br), .bresp(bre),
    .arvalid(arv), .arready(arr), .araddr(ara), .rvalid(rv), .rready(rr), .rdata(rd_),
    .rresp(rre));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register access with response check
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    HOST.wr(a, {24'h000000, d}, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    HOST.rd(a, d, r);
    chk("rresp", {30'h0, er}, {30'h0, r});
    if (er !== mpm_pkg::RESP_DECERR) chk("rdata", {16'h0000, ed}, d);
  endtask

  // One measurement result pulse, then look at the fault copy
  task automatic pulse(input logic [15:0] v, input logic exp_fcv);
    @(posedge clock);
    {mrv, mres} <= {1'b1, v};
    @(posedge clock);
    mrv <= 1'b0;
    #1 chk("fault_valid", {31'h0, exp_fcv}, {31'h0, fcv});
    if (exp_fcv) chk("fault_data", {16'h0000, v}, {16'h0000, fcd});
  endtask

  task automatic t_reset;
    rd(A_CTL, 16'h0000, OK);
    rd(A_SCN, 16'h0000, OK);
    rd(A_REG, 16'h0000, OK);
    rd(A_RES, 16'h0000, OK);
    rd(12'h000, 16'h0000, mpm_pkg::RESP_DECERR);
    wr(12'h004, 8'h5a, mpm_pkg::RESP_DECERR);
  endtask

  task automatic t_modes;
    logic [1:0] m;
    for (int i = 1; i < 5; i++)
    begin
      m = i[1:0];
      wr(A_SCN, {m, 6'h00}, OK);
      rd(A_SCN, {8'h00, m, 6'h00}, OK);
    end
  endtask

  task automatic t_silence;
    wr(A_CTL, 8'h02, OK);
    rd(A_CTL, 16'h0002, OK);
    repeat (5)
    begin
      repeat (SIL - 20) @(posedge clock);
      rd(A_SCN, 16'h0000, OK);
    end
    repeat (SIL + 10) @(posedge clock);
    rd(A_SCN, 16'h0080, OK);
  endtask

  task automatic t_lowpwr;
    int hi;
    int diff;
    pulse(16'h1234, 1'b1);
    rd(A_RES, 16'h0000, OK);
    {hi, diff} = {32'sd0, 32'sd0};
    repeat (2 * PER)
    begin
      @(posedge clock);
      #1 hi += mpe;
      diff += (mpe !== sre);
    end
    chk("window_cycles", 2 * WIN, hi);
    chk("strong_follows_window", 0, diff);
    wr(A_REG, 8'h02, OK);
    hi = 0;
    repeat (PER)
    begin
      @(posedge clock);
      #1 hi += (sre === 1'b1);
    end
    chk("strong_held", PER, hi);
    wr(A_CTL, 8'h00, OK);
    wr(A_SCN, 8'h00, OK);
    rd(A_RES, 16'h1234, OK);
  endtask

  task automatic t_storage_dormant_mode;
    wr(A_SCN, 8'hc0, OK);
    repeat (3) @(posedge clock);
    #1 chk("strong_storage_dormant_mode", 1, {31'h0, sre});
    chk("power_storage_dormant_mode", 0, {31'h0, mpe});
    rd(A_CTL, 16'h0000, ERR);
    wr(A_REG, 8'h00, ERR);
    rd(A_SCN, 16'h00c0, OK);
    pulse(16'h5678, 1'b0);
    wr(A_SCN, 8'h00, OK);
    rd(A_RES, 16'h1234, OK);
    rd(A_REG, 16'h0002, OK);
    wr(A_REG, 8'h00, OK);
    wr(A_SCN, 8'hc0, OK);
    repeat (3) @(posedge clock);
    #1 chk("weak_storage_dormant_mode", 0, {31'h0, sre});
    @(posedge clock);
    wakeup_n <= 1'b0;
    repeat (6) @(posedge clock);
    wakeup_n <= 1'b1;
    rd(A_SCN, 16'h0000, OK);
    // Reset while dormant must also bring the device back to idle
    wr(A_SCN, 8'hc0, OK);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(A_SCN, 16'h0000, OK);
    rd(A_RES, 16'h0000, OK);
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      miscompares++;
      test_done;
    end
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    t_reset;
    t_modes;
    t_silence;
    t_lowpwr;
    t_storage_dormant_mode;
    test_done;
  end
endmodule // mpm_power_mode_tb

`default_nettype wire
